// ==== adc_conversion_setup_control.sv ====
`timescale 1ns/1ns
module adc_conversion_setup_control
    import adc_setup_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYCLES,
    parameter bit LOW_VOLTAGE = 1'b0
) (
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire setup_t SETUP_I,
    input wire logic START_I,
    input wire logic RC_OSC_I,
    input wire logic COMPARATOR_I,
    output route_t ROUTE_O,
    output logic SAMPLE_O,
    output logic BUSY_O,
    output logic SETTLING_O,
    output logic DONE_O,
    output logic [9:0] RESULT_O
);
    typedef enum logic [2:0] {
        IDLE = 3'b001,
        WAIT = 3'b010,
        CONV = 3'b100
    } state_t;

    // Registered state and its next values
    state_t state_q;
    state_t state_d;
    logic [4:0] chan_q;
    logic [4:0] chan_d;
    logic [SETTLE_W-1:0] settle_q;
    logic [SETTLE_W-1:0] settle_d;
    logic [HALF_W-1:0] half_q;
    logic [HALF_W-1:0] half_d;
    logic [9:0] sar_q;
    logic [9:0] sar_d;
    logic [9:0] res_q;
    logic [9:0] res_d;
    logic done_q;
    logic done_d;
    route_t route_q;
    route_t route_d;
    // Synchroniser stages
    logic rc_s1_q;
    logic rc_s2_q;
    logic rc_s3_q;
    logic cmp_s1_q;
    logic cmp_s2_q;
    // Decoded strobes
    logic rc_tick;
    logic conv_run;
    logic half_tick;
    logic settled;
    logic decide;
    logic last_half;
    logic [3:0] bit_idx;

    // RC oscillator and comparator arrive asynchronously; three flops for the RC oscillator, two for the comparator
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            rc_s1_q <= RC_OSC_I;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
            cmp_s1_q <= COMPARATOR_I;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // Third RC stage only feeds the edge detector, never the first stage
    assign rc_tick = rc_s2_q ^ rc_s3_q;
    assign conv_run = state_q == CONV;

    conv_clock_gen u_clk (
        .clk_i(CLOCK_I),
        .rst_n_i(RESET_N_I),
        .sel_i(SETUP_I.conversion_clock_select),
        .rc_tick_i(rc_tick),
        .run_i(conv_run),
        .half_tick_o(half_tick)
    );

    // Bit decided at each odd half period below DECIDE_END, ten in all; bit 9 first
    assign bit_idx = 4'(9 - ((half_q - 5'h01) >> 1));
    assign settled = (settle_q == '0) && (SETUP_I.input_channel_select == chan_q);
    assign decide = half_tick && half_q[0] && (half_q < HALF_W'(DECIDE_END));
    assign last_half = half_tick && (half_q == HALF_W'(HALF_PERIODS - 1));

    // Channel tracker: any change of the field restarts the settling interval
    always_comb begin
        chan_d = SETUP_I.input_channel_select;
        settle_d = settle_q;
        if (SETUP_I.input_channel_select != chan_q) begin
            settle_d = SETTLE_W'(SETTLE);
        end else if (settle_q != '0) begin
            settle_d = settle_q - 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            chan_q <= 5'h00;
            settle_q <= '0;
        end else begin
            chan_q <= chan_d;
            settle_q <= settle_d;
        end
    end

    // Sequencer: deferred start, then a fixed count of half periods
    always_comb begin
        state_d = state_q;
        half_d = half_q;
        unique case (state_q)
            IDLE: begin
                if (START_I) begin
                    state_d = WAIT;
                end
            end
            WAIT: begin
                // Deferred rather than dropped, so software need not retry
                if (settled) begin
                    state_d = CONV;
                    half_d = '0;
                end
            end
            CONV: begin
                if (half_tick) begin
                    half_d = half_q + 1'b1;
                end
                if (last_half) begin
                    state_d = IDLE;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            state_q <= IDLE;
            half_q <= '0;
        end else begin
            state_q <= state_d;
            half_q <= half_d;
        end
    end

    // Trial register: keep or drop the trial bit, then try the next one down
    always_comb begin
        sar_d = sar_q;
        if (state_q == WAIT && settled) begin
            sar_d = 10'h200;
        end else if (state_q == CONV && decide) begin
            if (!cmp_s2_q) begin
                sar_d[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
                sar_d[bit_idx - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            sar_q <= 10'h000;
        end else begin
            sar_q <= sar_d;
        end
    end

    // Result holds until the next conversion ends, so software may read late
    always_comb begin
        res_d = res_q;
        done_d = 1'b0;
        if (state_q == CONV && last_half) begin
            res_d = sar_q;
            done_d = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            res_q <= 10'h000;
            done_q <= 1'b0;
        end else begin
            res_q <= res_d;
            done_q <= done_d;
        end
    end

    // Routing registered so switches move once per edge; 4.096V maps to supply on low-voltage parts
    always_comb begin
        route_d.channel_onehot = chan_onehot(SETUP_I.input_channel_select);
        route_d.pos_ref_onehot = 4'h0;
        if (LOW_VOLTAGE && SETUP_I.positive_reference_select == PREF_FIXED_4096) begin
            route_d.pos_ref_onehot[PREF_SUPPLY] = 1'b1;
        end else begin
            route_d.pos_ref_onehot[SETUP_I.positive_reference_select] = 1'b1;
        end
        route_d.neg_ref_is_pin = SETUP_I.negative_reference_select;
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            route_q <= '{channel_onehot: 17'h00001, pos_ref_onehot: 4'h1, neg_ref_is_pin: 1'b0};
        end else begin
            route_q <= route_d;
        end
    end

    assign ROUTE_O = route_q;

    assign SAMPLE_O = (state_q == CONV) && (half_q == '0);
    assign BUSY_O = state_q != IDLE;
    assign SETTLING_O = settle_q != '0;
    assign DONE_O = done_q;
    assign RESULT_O = res_q;
endmodule : adc_conversion_setup_control

// ==== adc_setup_pkg.sv ====
package adc_setup_pkg;
    localparam int CHAN_W = 5;
    localparam int CHAN_COUNT = 17;
    localparam int PREF_W = 2;
    localparam int CLKSEL_W = 3;
    localparam int RESULT_W = 10;
    // Positive reference codes
    localparam logic [1:0] PREF_PIN = 2'h0;
    localparam logic [1:0] PREF_SUPPLY = 2'h1;
    localparam logic [1:0] PREF_FIXED_2048 = 2'h2;
    localparam logic [1:0] PREF_FIXED_4096 = 2'h3;
    // Conversion clock codes; 3'h6 selects the dedicated RC oscillator, 3'h7 stops the clock
    localparam logic [2:0] CLK_DIV2 = 3'h0;
    localparam logic [2:0] CLK_DIV64 = 3'h5;
    localparam logic [2:0] CLK_RC = 3'h6;
    // Channel codes of the internal sources
    localparam logic [4:0] CHAN_TEMP = 5'h0E;
    localparam logic [4:0] CHAN_DAC = 5'h0F;
    localparam logic [4:0] CHAN_FIXED_BUF = 5'h10;
    // Conversion length in half bit periods: 11.5 periods
    localparam int HALF_PERIODS = 23;
    localparam int HALF_W = 5;
    // Odd half periods below this one decide a bit, ten in all
    localparam int DECIDE_END = 21;
    // Settling delay after a channel change
    localparam int SETTLE_NS = 5000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 12;

    typedef struct packed {
        logic [4:0] input_channel_select;
        logic [1:0] positive_reference_select;
        logic negative_reference_select;
        logic [2:0] conversion_clock_select;
    } setup_t;

    typedef struct packed {
        logic [16:0] channel_onehot;
        logic [3:0] pos_ref_onehot;
        logic neg_ref_is_pin;
    } route_t;

    // Decode of a channel code into a one-hot mux select
    function automatic logic [16:0] chan_onehot(input logic [4:0] ch);
        logic [16:0] r;
        r = 17'h00000;
        if (ch < 5'h11) begin
            r[ch] = 1'b1;
        end
        return r;
    endfunction : chan_onehot
endpackage : adc_setup_pkg

// ==== conv_clock_gen.sv ====
`timescale 1ns/1ns
// Makes one-cycle half-bit-period ticks from a divider or the RC oscillator
module conv_clock_gen
    import adc_setup_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] sel_i,
    input wire logic rc_tick_i,
    input wire logic run_i,
    output logic half_tick_o
);
    logic [5:0] div_q;
    logic [5:0] div_d;
    logic [5:0] half_limit;

    // Half of divisor 2^(sel+1) is 2^sel system cycles
    always_comb begin
        half_limit = 6'h01 << sel_i;
        div_d = div_q;
        half_tick_o = 1'b0;
        if (!run_i) begin
            div_d = 6'h00;
        end else if (sel_i == CLK_RC) begin
            half_tick_o = rc_tick_i;
        end else if (sel_i <= CLK_DIV64) begin
            if (div_q == half_limit - 6'h01) begin
                div_d = 6'h00;
                half_tick_o = 1'b1;
            end else begin
                div_d = div_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_d;
        end
    end
endmodule : conv_clock_gen

// ==== analog_source.sv ====
`timescale 1ns/1ns
// Far side: one held analog level and a free-running RC oscillator
module analog_source (
    input wire logic level_i,
    output logic cmp_o,
    output logic rc_o
);
    logic analog_in;
    // Pin kept as an input in analog mode, so no digital buffer loads the level
    assign analog_in = level_i;
    // A held level sits on one side of every trial, so the result is all ones or all zeros
    assign cmp_o = analog_in;
    // RC clock runs free and is unrelated to the system clock in phase and rate
    initial rc_o = 1'b0;
    always #23 rc_o = ~rc_o;
endmodule : analog_source

// ==== adc_setup_chk.sv ====
`timescale 1ns/1ns
module adc_setup_chk
    import adc_setup_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire setup_t SETUP_I,
    input wire logic START_I,
    input wire route_t ROUTE_O,
    input wire logic SAMPLE_O,
    input wire logic BUSY_O,
    input wire logic SETTLING_O,
    input wire logic DONE_O,
    input wire logic [9:0] RESULT_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);
    // Routing follows the fields one cycle late
    a_pos_ref: assert property ($past(RESET_N_I) |-> ROUTE_O.pos_ref_onehot ==
        4'h1 << $past(SETUP_I.positive_reference_select)) else $error("pos ref route wrong");
    a_neg_ref: assert property ($past(RESET_N_I) |-> ROUTE_O.neg_ref_is_pin ==
        $past(SETUP_I.negative_reference_select)) else $error("neg ref route wrong");
    a_chan_route: assert property ($past(RESET_N_I) |-> ROUTE_O.channel_onehot ==
        ($past(SETUP_I.input_channel_select) < 5'h11 ? 17'h00001 << $past(SETUP_I.input_channel_select) : 17'h00000))
        else $error("channel route wrong");
    // Handshake and timing of a conversion
    a_start_taken: assert property (START_I && !BUSY_O |=> BUSY_O) else $error("start lost");
    a_no_early_sample: assert property (SETTLING_O |-> !SAMPLE_O) else $error("sampled while settling");
    a_done_pulse: assert property (DONE_O |-> !BUSY_O ##1 (!DONE_O && BUSY_O == $past(START_I)))
        else $error("done not one cycle");
    a_result_hold: assert property (!DONE_O |-> $stable(RESULT_O)) else $error("result moved");
    a_done_bound: assert property ($rose(BUSY_O) && SETUP_I.conversion_clock_select < 3'h6
        |-> ##[20:1000] DONE_O) else $error("conversion length wrong");
endmodule : adc_setup_chk
bind adc_conversion_setup_control adc_setup_chk u_chk (.CLOCK_I, .RESET_N_I, .SETUP_I, .START_I, .ROUTE_O,
    .SAMPLE_O, .BUSY_O, .SETTLING_O, .DONE_O, .RESULT_O);

// ==== testbench.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("Error %0t: mismatch", $time); end end
module testbench;
    import adc_setup_pkg::*;
    logic CLOCK_I = 0, RESET_N_I = 0, START_I = 0, level = 0, sample, busy, settling, done, rc, cmp;
    setup_t setup = '0;
    setup_t r;
    route_t route;
    logic [9:0] result;
    logic [4:0] last_chan = 5'h00;
    int err_total = 0, checks_done = 0, cycles = 0, seed = 32'hd85bc126, k;
    always #5 CLOCK_I = ~CLOCK_I;
    analog_source u_src (.level_i(level), .cmp_o(cmp), .rc_o(rc));
    // Short settle count keeps the run brief
    adc_conversion_setup_control #(.SETTLE(4)) u_dut (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .SETUP_I(setup),
        .START_I(START_I), .RC_OSC_I(rc), .COMPARATOR_I(cmp), .ROUTE_O(route), .SAMPLE_O(sample),
        .BUSY_O(busy), .SETTLING_O(settling), .DONE_O(done), .RESULT_O(result));
    function automatic logic [16:0] exp_chan(input logic [4:0] c);
        return (c < 5'h11) ? 17'h00001 << c : 17'h00000;
    endfunction : exp_chan
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // Start right after a channel change; stray starts while busy must be ignored
    task automatic convert(input setup_t s, input logic lv);
        int n;
        @(negedge CLOCK_I);
        setup = s;
        level = lv;
        @(negedge CLOCK_I);
        `CHK(route.channel_onehot, exp_chan(s.input_channel_select))
        `CHK(route.pos_ref_onehot, 4'h1 << s.positive_reference_select)
        `CHK(route.neg_ref_is_pin, s.negative_reference_select)
        `CHK(settling, 1'(s.input_channel_select != last_chan))
        last_chan = s.input_channel_select;
        START_I = 1'b1;
        @(negedge CLOCK_I);
        `CHK(busy, 1'b1)
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            START_I = 1'($random(seed));
            @(negedge CLOCK_I);
            n++;
        end
        START_I = 1'b0;
        `CHK(done, 1'b1)
        `CHK(result, {10{lv}})
        $display("test clock %0d channel %0d done", s.conversion_clock_select, s.input_channel_select);
    endtask : convert
    // Hang guard
    always @(posedge CLOCK_I) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            $display("Error %0t: timeout", $time);
            conclude();
        end
    end
    initial begin
        repeat (5) @(negedge CLOCK_I);
        RESET_N_I = 1'b1;
        for (k = 0; k < 7; k++) convert({5'(k + 14), 2'(k), 1'(k), 3'(k)}, k[0]);
        for (k = 0; k < 12; k++) begin
            r = 11'($random(seed));
            if (r.conversion_clock_select == 3'h7) r.conversion_clock_select = CLK_RC;
            convert(r, 1'($random(seed)));
        end
        conclude();
    end
endmodule : testbench
